// >>> rtl/asi_defs.svh
`ifndef ASI_DEFS_SVH
`define ASI_DEFS_SVH

// register indices; byte address is four times the index
`define ASI_IDX_RATE_MODE 8'h10
`define ASI_IDX_CTRL_STATUS 8'h11
`define ASI_IDX_RX_DATA 8'h12
`define ASI_IDX_TX_DATA 8'h13
`define ASI_ADDR_W 8

// rate/mode field positions
`define ASI_RM_SS_LO 0
`define ASI_RM_SS_HI 1
`define ASI_RM_CC_LO 2
`define ASI_RM_CC_HI 3
`define ASI_RM_RESET 4'h0

// control/status field positions
`define ASI_CS_WAKE 0
`define ASI_CS_TE 1
`define ASI_CS_TIE 2
`define ASI_CS_RE 3
`define ASI_CS_RIE 4
`define ASI_CS_TRANSMIT_EMPTY_FLAG 5
`define ASI_CS_OVERRUN_FRAMING_FLAG 6
`define ASI_CS_RECEIVE_FULL_FLAG 7
`define ASI_CS_WR_MSB 4
`define ASI_CS_RESET 8'h20

// counter bit that toggles at 8x bit rate, per speed code (/2, /16, /128, /512)
`define ASI_SUB_BIT_0 4'd0
`define ASI_SUB_BIT_1 4'd3
`define ASI_SUB_BIT_2 4'd6
`define ASI_SUB_BIT_3 4'd8
// counter bit three above the sub bit is the 1x clock, high in the second half-bit
`define ASI_BIT_CLK_OFS 4'd3

// frame shape
`define ASI_PREAMBLE_BITS 4'd9
`define ASI_FRAME_BITS 4'd10
`define ASI_IDLE_ONES 4'd10
`define ASI_HALF_BIT 3'd3
`define ASI_SUB_LAST 3'd7

`endif

// >>> rtl/asi_pkg.sv
package asi_pkg;

    // apb request fields that travel together
    typedef struct packed {
        logic [7:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
    } asi_apb_req_s;

    // serial pins as seen by the block
    typedef struct packed {
        logic out;
        logic oe;
    } asi_pin_drive_s;

    // transmitter states
    typedef enum logic [3:0] {
        TX_OFF = 4'b0001,
        TX_PRE = 4'b0010,
        TX_IDLE = 4'b0100,
        TX_SHIFT = 4'b1000
    } asi_tx_e;

    // receiver states
    typedef enum logic [2:0] {
        RX_HUNT = 3'b001,
        RX_START = 3'b010,
        RX_BITS = 3'b100
    } asi_rx_e;

endpackage

// >>> rtl/asi_serial.sv
`timescale 1ns/1ps
`include "asi_defs.svh"
module asi_serial
    import asi_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire asi_pkg::asi_apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer free-running counter, same clock
    input wire logic [15:0] timer_count,
    // port 2 direction writes for bits 2..4
    input wire logic p2_ddr_we,
    input wire logic [2:0] p2_ddr_wdata,
    // serial clock pin
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    // serial data pins
    input wire logic serial_input_pin,
    output logic serial_output_pin,
    output logic serial_output_pin_oe,
    // port 2 direction bits 2..4 as seen by the port
    output logic [2:0] p2_ddr_bits,
    // shared timer/serial interrupt request
    output logic timer_serial_irq
);
    import asi_pkg::*;

    // select the counter bit that ticks at 8x bit rate
    function automatic logic [3:0] sub_bit_pos(input logic [1:0] ss);
        unique case (ss)
            2'b00: sub_bit_pos = `ASI_SUB_BIT_0;
            2'b01: sub_bit_pos = `ASI_SUB_BIT_1;
            2'b10: sub_bit_pos = `ASI_SUB_BIT_2;
            2'b11: sub_bit_pos = `ASI_SUB_BIT_3;
        endcase
    endfunction

    // registers visible to software
    logic [3:0] rate_mode_reg; // write-only, reads zero
    logic [4:0] ctrl_reg; // writable bits of control/status
    logic transmit_empty_flag_reg, overrun_framing_flag_reg, receive_full_flag_reg; // status flags
    logic [7:0] tx_data_reg; // write-only holding register
    logic [7:0] rx_data_reg; // read-only holding register
    logic transmit_empty_flag_armed_reg; // status read seen with empty set
    logic rx_armed_reg; // status read seen with full/error set

    // pin synchronisers; first stage feeds only the second
    logic [1:0] clk_pin_sync_reg;
    logic clk_pin_prev_reg;
    logic [1:0] rx_pin_sync_reg;

    // rate generation
    logic sub_prev_reg; // previous level of chosen counter bit
    logic [2:0] tx_sub_reg; // divides 8x ticks to bit ticks

    // transmitter
    asi_tx_e tx_state_reg;
    logic [3:0] tx_cnt_reg;
    logic [9:0] tx_shift_reg;
    logic te_prev_reg;

    // receiver
    asi_rx_e rx_state_reg;
    logic [2:0] rx_sub_reg;
    logic [3:0] rx_cnt_reg;
    logic [7:0] rx_shift_reg;
    logic [2:0] idle_sub_reg;
    logic [3:0] idle_cnt_reg;

    // direction bits and their locks
    logic clk_dir_reg, rx_dir_reg, tx_dir_reg;
    logic tx_lock_reg, rx_lock_reg;

    // decoded fields
    wire [1:0] speed_sel = rate_mode_reg[`ASI_RM_SS_HI:`ASI_RM_SS_LO];
    wire clock_ctrl_hi = rate_mode_reg[`ASI_RM_CC_HI];
    wire clock_ctrl_lo = rate_mode_reg[`ASI_RM_CC_LO];
    wire idle_wake_arm = ctrl_reg[`ASI_CS_WAKE];
    wire transmit_enable = ctrl_reg[`ASI_CS_TE];
    wire transmit_irq_enable = ctrl_reg[`ASI_CS_TIE];
    wire receive_enable = ctrl_reg[`ASI_CS_RE];
    wire receive_irq_enable = ctrl_reg[`ASI_CS_RIE];
    wire ext_clock = clock_ctrl_hi & clock_ctrl_lo;
    wire unit_used = clock_ctrl_hi | clock_ctrl_lo;

    // apb decode; printed offsets are indices, byte address is index times four
    wire [`ASI_ADDR_W-1:0] idx = {2'b00, apb_req.paddr[7:2]};
    wire hit_rm = idx == `ASI_IDX_RATE_MODE;
    wire hit_cs = idx == `ASI_IDX_CTRL_STATUS;
    wire hit_rx = idx == `ASI_IDX_RX_DATA;
    wire hit_tx = idx == `ASI_IDX_TX_DATA;
    wire mapped = (hit_rm | hit_cs | hit_rx | hit_tx) & (apb_req.paddr[1:0] == 2'b00);
    wire access = psel & penable & clk_en;
    wire wr_ok = access & apb_req.pwrite & mapped;
    wire rd_ok = access & ~apb_req.pwrite & mapped;
    wire [7:0] status_byte = {receive_full_flag_reg, overrun_framing_flag_reg, transmit_empty_flag_reg, ctrl_reg};
    wire [7:0] rd_byte = hit_cs ? status_byte : hit_rx ? rx_data_reg : 8'h00;

    // 8x tick: internal from timer counter, external from synchronised pin
    wire sub_lvl = timer_count[sub_bit_pos(speed_sel)];
    wire int_tick = sub_lvl & ~sub_prev_reg;
    wire ext_tick = clk_pin_sync_reg[1] & ~clk_pin_prev_reg;
    wire sub_tick = clk_en & unit_used & (ext_clock ? ext_tick : int_tick);
    wire bit_tick = sub_tick & (tx_sub_reg == `ASI_SUB_LAST);
    wire [3:0] clk_out_pos = sub_bit_pos(speed_sel) + `ASI_BIT_CLK_OFS;
    wire rx_line = rx_pin_sync_reg[1];

    // receiver events at each bit sample and at the stop bit, and the idle-ones wake release
    wire rx_sample = sub_tick & (rx_state_reg == RX_BITS) & (rx_sub_reg == `ASI_SUB_LAST);
    // start is sampled in RX_START, so the stop bit is the ninth sample here
    wire rx_stop = rx_sample & (rx_cnt_reg == `ASI_FRAME_BITS - 4'd2);
    wire rx_flags_on = ~idle_wake_arm;
    wire rx_good = rx_stop & rx_line & ~receive_full_flag_reg & rx_flags_on;
    wire rx_error = rx_stop & (~rx_line | receive_full_flag_reg) & rx_flags_on;
    wire idle_done = sub_tick & rx_line & (idle_sub_reg == `ASI_SUB_LAST)
        & (idle_cnt_reg == `ASI_IDLE_ONES - 4'd1);

    // transmitter load point and clear events
    wire tx_load = bit_tick & ~transmit_empty_flag_reg
        & ((tx_state_reg == TX_IDLE)
        | ((tx_state_reg == TX_SHIFT) & (tx_cnt_reg == `ASI_FRAME_BITS - 4'd1)));
    wire transmit_empty_flag_clr = wr_ok & hit_tx & transmit_empty_flag_armed_reg;
    wire rx_clr = rd_ok & hit_rx & rx_armed_reg;
    wire te_rise = clk_en & transmit_enable & ~te_prev_reg;

    // apb answers in the access cycle, no wait states
    assign pready = 1'b1;

    // read data and error flop; unmapped gets error, and zero data unless its index is control/status or receive data
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en && psel && !penable) begin
            prdata <= {24'h00_0000, rd_byte};
            pslverr <= ~mapped;
        end
    end

    // software-written control bits
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rate_mode_reg <= `ASI_RM_RESET;
            ctrl_reg <= 5'(`ASI_CS_RESET);
        end else begin
            if (wr_ok && hit_rm) begin
                rate_mode_reg <= apb_req.pwdata[3:0];
            end
            if (wr_ok && hit_cs) begin
                ctrl_reg <= apb_req.pwdata[`ASI_CS_WR_MSB:0];
            end else if (idle_done) begin
                ctrl_reg[`ASI_CS_WAKE] <= 1'b0;
            end
        end
    end

    // status flags; a set in the same cycle as a clear wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            transmit_empty_flag_reg <= 1'b1;
            overrun_framing_flag_reg <= 1'b0;
            receive_full_flag_reg <= 1'b0;
            transmit_empty_flag_armed_reg <= 1'b0;
            rx_armed_reg <= 1'b0;
            rx_data_reg <= 8'h00;
            tx_data_reg <= 8'h00;
        end else begin
            if (tx_load) begin
                transmit_empty_flag_reg <= 1'b1;
            end else if (transmit_empty_flag_clr) begin
                transmit_empty_flag_reg <= 1'b0;
            end
            if (rx_good) begin
                receive_full_flag_reg <= 1'b1;
                rx_data_reg <= rx_shift_reg;
            end else if (rx_clr) begin
                receive_full_flag_reg <= 1'b0;
            end
            if (rx_error) begin
                overrun_framing_flag_reg <= 1'b1;
            end else if (rx_clr) begin
                overrun_framing_flag_reg <= 1'b0;
            end
            if (wr_ok && hit_tx) begin
                tx_data_reg <= apb_req.pwdata[7:0];
            end
            // arming remembers the status read until the data access
            if (rd_ok && hit_cs) begin
                transmit_empty_flag_armed_reg <= transmit_empty_flag_reg;
                rx_armed_reg <= receive_full_flag_reg | overrun_framing_flag_reg;
            end else begin
                if (transmit_empty_flag_clr) transmit_empty_flag_armed_reg <= 1'b0;
                if (rx_clr) rx_armed_reg <= 1'b0;
            end
        end
    end

    // synchronisers and tick edge history
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clk_pin_sync_reg <= 2'b00;
            clk_pin_prev_reg <= 1'b0;
            rx_pin_sync_reg <= 2'b11;
            sub_prev_reg <= 1'b0;
            tx_sub_reg <= 3'd0;
        end else if (clk_en) begin
            clk_pin_sync_reg <= {clk_pin_sync_reg[0], serial_clock_pin_in};
            clk_pin_prev_reg <= clk_pin_sync_reg[1];
            rx_pin_sync_reg <= {rx_pin_sync_reg[0], serial_input_pin};
            sub_prev_reg <= sub_lvl;
            if (sub_tick) tx_sub_reg <= tx_sub_reg + 3'd1;
        end
    end

    // transmitter: preamble, idle ones, or ten-bit frames
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_reg <= TX_OFF;
            tx_cnt_reg <= 4'd0;
            tx_shift_reg <= 10'h3ff;
            te_prev_reg <= 1'b0;
        end else if (clk_en) begin
            te_prev_reg <= transmit_enable;
            if (!transmit_enable) begin
                tx_state_reg <= TX_OFF;
                tx_shift_reg <= 10'h3ff;
            end else if (te_rise) begin
                tx_state_reg <= TX_PRE;
                tx_cnt_reg <= 4'd0;
                tx_shift_reg <= 10'h3ff;
            end else if (tx_load) begin
                // start zero, data lsb first, stop one
                tx_shift_reg <= {1'b1, tx_data_reg, 1'b0};
                tx_cnt_reg <= 4'd0;
                tx_state_reg <= TX_SHIFT;
            end else if (bit_tick) begin
                tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                unique case (tx_state_reg)
                    TX_PRE: begin
                        tx_cnt_reg <= tx_cnt_reg + 4'd1;
                        if (tx_cnt_reg == `ASI_PREAMBLE_BITS - 4'd1) tx_state_reg <= TX_IDLE;
                    end
                    TX_SHIFT: begin
                        tx_cnt_reg <= tx_cnt_reg + 4'd1;
                        if (tx_cnt_reg == `ASI_FRAME_BITS - 4'd1) tx_state_reg <= TX_IDLE;
                    end
                    TX_IDLE: tx_state_reg <= TX_IDLE; // empty: keep sending ones
                    TX_OFF: tx_state_reg <= TX_OFF;
                endcase
            end
        end
    end

    // receiver: hunt first zero, centre on start, sample nine more bits
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_reg <= RX_HUNT;
            rx_sub_reg <= 3'd0;
            rx_cnt_reg <= 4'd0;
            rx_shift_reg <= 8'h00;
        end else if (clk_en) begin
            if (!receive_enable) begin
                rx_state_reg <= RX_HUNT;
            end else if (sub_tick) begin
                rx_sub_reg <= rx_sub_reg + 3'd1;
                unique case (rx_state_reg)
                    RX_HUNT: begin
                        rx_sub_reg <= 3'd0;
                        if (!rx_line) rx_state_reg <= RX_START;
                    end
                    RX_START: begin
                        // half a bit later the start bit is checked at its centre
                        if (rx_sub_reg == `ASI_HALF_BIT) begin
                            rx_sub_reg <= 3'd0;
                            rx_cnt_reg <= 4'd0;
                            rx_state_reg <= rx_line ? RX_HUNT : RX_BITS;
                        end
                    end
                    RX_BITS: begin
                        if (rx_sub_reg == `ASI_SUB_LAST) begin
                            rx_cnt_reg <= rx_cnt_reg + 4'd1;
                            if (rx_cnt_reg < `ASI_FRAME_BITS - 4'd2) begin
                                rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                            end
                            if (rx_stop) rx_state_reg <= RX_HUNT;
                        end
                    end
                endcase
            end
        end
    end

    // idle-ones counter for the wake-up release, one count per bit time
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            idle_sub_reg <= 3'd0;
            idle_cnt_reg <= 4'd0;
        end else if (clk_en && sub_tick) begin
            if (!rx_line || !idle_wake_arm) begin
                idle_sub_reg <= 3'd0;
                idle_cnt_reg <= 4'd0;
            end else begin
                idle_sub_reg <= idle_sub_reg + 3'd1;
                if (idle_sub_reg == `ASI_SUB_LAST) idle_cnt_reg <= idle_cnt_reg + 4'd1;
            end
        end
    end

    // port 2 direction bits with forcing and locks
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clk_dir_reg <= 1'b0;
            rx_dir_reg <= 1'b0;
            tx_dir_reg <= 1'b0;
            tx_lock_reg <= 1'b0;
            rx_lock_reg <= 1'b0;
        end else if (clk_en) begin
            if (transmit_enable) tx_lock_reg <= 1'b1;
            if (receive_enable) rx_lock_reg <= 1'b1;
            if (clock_ctrl_hi) begin
                clk_dir_reg <= ~clock_ctrl_lo;
            end else if (p2_ddr_we) begin
                clk_dir_reg <= p2_ddr_wdata[0];
            end
            if (rx_lock_reg || receive_enable) begin
                rx_dir_reg <= 1'b0;
            end else if (p2_ddr_we) begin
                rx_dir_reg <= p2_ddr_wdata[1];
            end
            if (tx_lock_reg || transmit_enable) begin
                tx_dir_reg <= 1'b1;
            end else if (p2_ddr_we) begin
                tx_dir_reg <= p2_ddr_wdata[2];
            end
        end
    end

    // registered pin drives and interrupt; the clock pin is 1x, rising mid-bit
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe <= 1'b0;
            serial_output_pin <= 1'b1;
            serial_output_pin_oe <= 1'b0;
            p2_ddr_bits <= 3'b000;
            timer_serial_irq <= 1'b0;
        end else if (clk_en) begin
            serial_clock_pin_oe <= clock_ctrl_hi & ~clock_ctrl_lo;
            serial_clock_pin_out <= timer_count[clk_out_pos];
            serial_output_pin <= tx_shift_reg[0];
            serial_output_pin_oe <= transmit_enable;
            p2_ddr_bits <= {tx_dir_reg, rx_dir_reg, clk_dir_reg};
            timer_serial_irq <= (transmit_irq_enable & transmit_empty_flag_reg)
                | (receive_irq_enable & (receive_full_flag_reg | overrun_framing_flag_reg));
        end
    end

endmodule

// >>> verification/asi_serial_assertions.sv
`timescale 1ns/1ps
`include "asi_defs.svh"
module asi_serial_checker
    import asi_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire asi_pkg::asi_apb_req_s apb_req,
    input wire logic [31:0] prdata,
    // pins and interrupt
    input wire logic serial_clock_pin_oe,
    input wire logic serial_output_pin,
    input wire logic serial_output_pin_oe,
    input wire logic [2:0] p2_ddr_bits,
    input wire logic timer_serial_irq
);
    localparam logic [7:0] A_RM = 8'(`ASI_IDX_RATE_MODE * 4);
    localparam logic [7:0] A_CS = 8'(`ASI_IDX_CTRL_STATUS * 4);
    localparam logic [7:0] A_TX = 8'(`ASI_IDX_TX_DATA * 4);
    // access phase as the slave takes it
    wire acc = psel && penable && clk_en;
    wire wr_cs = acc && apb_req.pwrite && apb_req.paddr == A_CS;
    wire wr_rm = acc && apb_req.pwrite && apb_req.paddr == A_RM;
    wire rd_wo = acc && !apb_req.pwrite && (apb_req.paddr == A_RM || apb_req.paddr == A_TX);
    logic [7:0] cs_q; // shadow of written control bits
    logic [1:0] cc_q; // shadow of clock-control field
    logic re_seen; // receive enable was ever written set
    logic te_seen; // transmit enable was ever written set
    wire te = cs_q[1];
    wire masked = !cs_q[2] && !cs_q[4]; // both interrupt enables clear
    // shadows follow software writes, not the design's state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cs_q <= 8'h00;
            cc_q <= 2'b00;
            re_seen <= 1'b0;
            te_seen <= 1'b0;
        end else begin
            if (wr_cs) cs_q <= apb_req.pwdata[7:0];
            if (wr_rm) cc_q <= apb_req.pwdata[3:2];
            if (wr_cs && apb_req.pwdata[3]) re_seen <= 1'b1;
            if (wr_cs && apb_req.pwdata[1]) te_seen <= 1'b1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wo_read_zero_a: assert property (rd_wo |-> prdata == 32'h0)
        else $error("write-only register read back nonzero");
    clk_oe_code_a: assert property (
        cc_q == $past(cc_q) && cc_q == $past(cc_q, 2) |-> serial_clock_pin_oe == (cc_q == 2'b10))
        else $error("clock pin enable does not match clock code");
    clk_dir_force_a: assert property (
        cc_q[1] && cc_q == $past(cc_q) && cc_q == $past(cc_q, 2) |-> p2_ddr_bits[0] == !cc_q[0])
        else $error("clock pin direction not forced");
    tx_dir_hold_a: assert property ($past(te_seen, 2) |-> p2_ddr_bits[2])
        else $error("transmit pin direction cleared");
    tx_dir_set_a: assert property ($past(te, 2) |-> p2_ddr_bits[2])
        else $error("transmit pin direction not set");
    rx_dir_lock_a: assert property ($past(re_seen, 2) |-> !p2_ddr_bits[1])
        else $error("receive pin direction not held clear");
    tx_oe_follow_a: assert property (
        te == $past(te) && te == $past(te, 2) |-> serial_output_pin_oe == te)
        else $error("output pin enable differs from transmit enable");
    irq_masked_a: assert property (
        masked && $past(masked) && $past(masked, 2) |-> !timer_serial_irq)
        else $error("interrupt raised with both enables clear");
    preamble_ones_a: assert property ($rose(serial_output_pin_oe) |-> serial_output_pin [*8])
        else $error("preamble does not start with ones");
endmodule
bind asi_serial asi_serial_checker i_asi_serial_checker (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .apb_req(apb_req), .prdata(prdata), .serial_clock_pin_oe(serial_clock_pin_oe),
    .serial_output_pin(serial_output_pin), .serial_output_pin_oe(serial_output_pin_oe),
    .p2_ddr_bits(p2_ddr_bits), .timer_serial_irq(timer_serial_irq)
);

// >>> verification/asi_remote_node.sv
`timescale 1ns/1ps
module asi_remote_node #(
    parameter int BIT = 16
) (
    // clock shared with the bench
    input wire logic mclk,
    // line from the device, line to the device
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] rx_byte = 8'h00; // last byte heard
    logic rx_stop = 1'b0; // stop level of last frame
    int rx_count = 0; // frames heard
    initial line_out = 1'b1; // idle mark
    // one frame, start low, lsb first; stop may be broken on purpose
    task automatic send(input logic [7:0] data, input logic stop);
        logic [9:0] frame;
        frame = {stop, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= frame[i];
            repeat (BIT) @(posedge mclk);
        end
        line_out <= 1'b1;
        @(posedge mclk); // one edge between frames, one drive per step
    endtask
    // receiver: sync on first low, then sample bit centres
    initial begin
        forever begin
            @(posedge mclk);
            if (line_in === 1'b0) begin
                repeat (BIT / 2) @(posedge mclk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge mclk);
                    rx_byte[i] = line_in;
                end
                repeat (BIT) @(posedge mclk);
                rx_stop = line_in;
                rx_count++;
            end
        end
    end
endmodule

// >>> verification/asi_serial_tb_top.sv
`timescale 1ns/1ps
`include "asi_defs.svh"
module asi_serial_tb_top;
    import asi_pkg::*;
    localparam logic [7:0] A_RM = 8'(`ASI_IDX_RATE_MODE * 4);
    localparam logic [7:0] A_CS = 8'(`ASI_IDX_CTRL_STATUS * 4);
    localparam logic [7:0] A_RX = 8'(`ASI_IDX_RX_DATA * 4);
    localparam logic [7:0] A_TX = 8'(`ASI_IDX_TX_DATA * 4);
    localparam int BIT = 16; // clocks per bit at speed code 00
    logic mclk, reset_n, psel, penable, pready, pslverr, p2_ddr_we;
    asi_apb_req_s apb_req;
    logic [31:0] prdata;
    logic [15:0] timer_count = 16'h0000;
    logic [2:0] p2_ddr_wdata, p2_ddr_bits;
    logic clk_out, clk_oe, rx_line, tx_out, tx_oe, irq;
    wire tx_line = tx_oe ? tx_out : 1'b1; // pull-up holds idle mark
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int per[4] = '{16, 128, 1024, 4096}; // bit period per speed code
    logic ext_clk = 1'b0; // external 8x clock, one toggle per bus clock
    asi_serial i_asi_serial (
        .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .psel(psel), .penable(penable),
        .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_count(timer_count), .p2_ddr_we(p2_ddr_we), .p2_ddr_wdata(p2_ddr_wdata),
        .serial_clock_pin_in(ext_clk), .serial_clock_pin_out(clk_out),
        .serial_clock_pin_oe(clk_oe), .serial_input_pin(rx_line), .serial_output_pin(tx_out),
        .serial_output_pin_oe(tx_oe), .p2_ddr_bits(p2_ddr_bits), .timer_serial_irq(irq)
    );
    asi_remote_node #(.BIT(BIT)) i_asi_remote_node (
        .mclk(mclk), .line_in(tx_line), .line_out(rx_line)
    );
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // free-running timer and hang guard
    always @(posedge mclk) begin
        timer_count <= reset_n ? timer_count + 16'h0001 : 16'h0000;
        cyc <= cyc + 1;
        ext_clk <= ~ext_clk;
        if (cyc == 40000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        apb_req <= '{paddr: a, pwrite: w, pwdata: d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, {24'h0, d}, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        chk(r, {24'h0, exp});
    endtask
    task automatic ddr_wr(input logic [2:0] v);
        @(posedge mclk);
        p2_ddr_we <= 1'b1;
        p2_ddr_wdata <= v;
        @(posedge mclk);
        p2_ddr_we <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    // status with flags, data, then status cleared; irq follows flags (rie set)
    task automatic rx_clear(input logic [7:0] st, input logic [7:0] dat);
        repeat (4) @(posedge mclk);
        chk({31'h0, irq}, {31'h0, st[7] | st[6]});
        rd_chk(A_CS, st);
        rd_chk(A_RX, dat);
        rd_chk(A_CS, 8'h3a);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] rd;
        logic err;
        time t0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        apb_req = '0;
        p2_ddr_we = 1'b0;
        p2_ddr_wdata = 3'b000;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd_chk(A_CS, 8'h20);
        rd_chk(A_RM, 8'h00);
        rd_chk(A_TX, 8'h00);
        apb(8'h45, 1'b0, 32'h0, rd, err);
        chk({31'h0, err}, 32'h1);
        $display("reset test done");
        // internal clock, fastest rate, both directions on
        wr(A_RM, 8'h04);
        wr(A_CS, 8'hca);
        rd_chk(A_CS, 8'h2a);
        ddr_wr(3'b011);
        chk(32'(p2_ddr_bits), 32'h5);
        repeat (10 * BIT) @(posedge mclk);
        rd_chk(A_CS, 8'h2a);
        wr(A_TX, 8'ha5);
        for (int i = 0; i < 30 * BIT && i_asi_remote_node.rx_count == 0; i++) @(posedge mclk);
        chk(32'(i_asi_remote_node.rx_byte), 32'ha5);
        chk(32'(i_asi_remote_node.rx_stop), 32'h1);
        rd_chk(A_CS, 8'h2a);
        repeat (20 * BIT) @(posedge mclk);
        chk(32'(i_asi_remote_node.rx_count), 32'h1);
        $display("transmit test done");
        wr(A_CS, 8'h0e);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        wr(A_CS, 8'h1a);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        $display("interrupt test done");
        i_asi_remote_node.send(8'h3c, 1'b1);
        rx_clear(8'hba, 8'h3c);
        i_asi_remote_node.send(8'h11, 1'b1);
        i_asi_remote_node.send(8'h22, 1'b1);
        rx_clear(8'hfa, 8'h11);
        wr(A_CS, 8'h1b);
        i_asi_remote_node.send(8'h00, 1'b1);
        repeat (12 * BIT) @(posedge mclk);
        rx_clear(8'h3a, 8'h11);
        i_asi_remote_node.send(8'h55, 1'b0);
        rx_clear(8'h7a, 8'h11);
        $display("receive test done");
        wr(A_RM, 8'h08);
        repeat (3) @(posedge mclk);
        chk({30'h0, clk_oe, p2_ddr_bits[0]}, 32'h3);
        wr(A_RM, 8'h0c);
        ddr_wr(3'b111);
        chk({30'h0, clk_oe, p2_ddr_bits[0]}, 32'h0);
        wr(A_RM, 8'h04);
        repeat (3) @(posedge mclk);
        chk({31'h0, p2_ddr_bits[0]}, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wr(A_RM, 8'h08 | 8'(s));
            @(posedge clk_out);
            @(posedge clk_out);
            t0 = $time;
            @(posedge clk_out);
            chk(32'(($time - t0) / 8), 32'(per[s]));
        end
        $display("clock test done");
        // receive on the external 8x clock, then drop transmit enable
        wr(A_RM, 8'h0c);
        i_asi_remote_node.send(8'h69, 1'b1);
        rx_clear(8'hba, 8'h69);
        wr(A_CS, 8'h18);
        repeat (3) @(posedge mclk);
        chk(32'(p2_ddr_bits), 32'h4);
        $display("external clock test done");
        give_verdict();
    end
endmodule
